/* ctec_ev_src.sv */
module ctec_ev_src (
  input wire clk,
  output logic event_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial event_input_pin = 1'b0;
  // each level stands six cycles: above the two-cycle minimum and long enough for the count to land
  task automatic drive(input logic v);
    event_input_pin <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule // ctec_ev_src

/* ctec_map.vh */
`ifndef CTEC_MAP_VH
`define CTEC_MAP_VH

// register byte offsets
`define CTEC_ADDR_W 8
`define CTEC_OFF_MODE 8'h00
`define CTEC_OFF_CLKSEL 8'h04
`define CTEC_OFF_OUTCTL 8'h08
`define CTEC_OFF_CMP_LO 8'h0C
`define CTEC_OFF_CMP_HI 8'h10
`define CTEC_OFF_COUNT 8'h14
`define CTEC_OFF_IRQ_STAT 8'h18
`define CTEC_OFF_IRQ_MASK 8'h1C
`define CTEC_OFF_OSC 8'h20

// field positions
`define CTEC_MODE_CE 0
`define CTEC_MODE_CASC 2
`define CTEC_OUTC_OE1 0
`define CTEC_OUTC_LVR1 2
`define CTEC_OUTC_LVS1 3
`define CTEC_OUTC_OE2 4
`define CTEC_OUTC_OUTPUT_RESET_LEVEL_TWO 6
`define CTEC_OUTC_OUTPUT_SET_LEVEL_TWO 7
`define CTEC_IRQ_LO 0
`define CTEC_IRQ_HI 1
`define CTEC_OSC_DIV 0

// reset values
`define CTEC_CMP_RST 8'h00
`define CTEC_CLKSEL_RST 4'h0
`define CTEC_MASK_RST 2'h3
`define CTEC_OSC_RST 1'h0

// count clock selection codes
`define CTEC_SEL_EV_FALL 4'h0
`define CTEC_SEL_EV_RISE 4'h1
`define CTEC_PRE_W 12

`endif

/* ctec_stage.v */
module ctec_stage #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire step,
  input wire zero,
  input wire [WIDTH-1:0] compare,
  output reg [WIDTH-1:0] count,
  output wire match,
  output wire at_max
);

  assign match = (count == compare);
  assign at_max = &count;

  // zero wins over step; a compare below the count simply lets it wrap
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (zero) begin
      count <= {WIDTH{1'b0}};
    end else if (step) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // ctec_stage

/* ctec_tick_gen.v */
`include "ctec_map.vh"

module ctec_tick_gen (
  input wire clk,
  input wire rst_n,
  input wire event_input_pin,
  input wire [3:0] count_clock_select_field,
  input wire oscillator_divide_bit,
  output reg tick
);

  reg [1:0] ev_sync;
  reg ev_prev;
  reg [`CTEC_PRE_W-1:0] pre;
  wire [3:0] base_shift;
  wire [3:0] shift;
  wire [`CTEC_PRE_W-1:0] pre_mask;
  wire pre_hit;
  wire ev_rise;
  wire ev_fall;
  wire is_internal;

  // divide exponent of fx for each internal selection; zero marks event or prohibited codes
  function [3:0] ctec_shift_of;
    input [3:0] sel;
    begin
      case (sel)
        4'h6: ctec_shift_of = 4'h1;
        4'h7: ctec_shift_of = 4'h2;
        4'h8: ctec_shift_of = 4'h3;
        4'h9: ctec_shift_of = 4'h4;
        4'hA: ctec_shift_of = 4'h5;
        4'hB: ctec_shift_of = 4'h6;
        4'hC: ctec_shift_of = 4'h7;
        4'hD: ctec_shift_of = 4'h8;
        4'hE: ctec_shift_of = 4'h9;
        4'hF: ctec_shift_of = 4'hB;
        default: ctec_shift_of = 4'h0;
      endcase
    end
  endfunction

  assign base_shift = ctec_shift_of(count_clock_select_field);
  assign is_internal = (base_shift != 4'h0);
  // slower oscillator setting doubles every internal period
  assign shift = base_shift + {3'b000, ~oscillator_divide_bit};
  assign pre_mask = ~({`CTEC_PRE_W{1'b1}} << shift);
  assign pre_hit = ((pre & pre_mask) == pre_mask);
  assign ev_rise = ev_sync[1] & ~ev_prev;
  assign ev_fall = ~ev_sync[1] & ev_prev;

  // prescaler free-runs and is never restarted, so a start may land anywhere in a period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= {`CTEC_PRE_W{1'b0}};
    end else begin
      pre <= pre + {{(`CTEC_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_sync <= 2'b00;
      ev_prev <= 1'b0;
    end else begin
      ev_sync <= {ev_sync[0], event_input_pin};
      ev_prev <= ev_sync[1];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else if (count_clock_select_field == `CTEC_SEL_EV_RISE) begin
      tick <= ev_rise;
    end else if (count_clock_select_field == `CTEC_SEL_EV_FALL) begin
      tick <= ev_fall;
    end else begin
      tick <= is_internal & pre_hit;
    end
  end

endmodule // ctec_tick_gen

/* ctec_top.v */
`include "ctec_map.vh"

module ctec_top #(
  parameter AW = `CTEC_ADDR_W
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire event_input_pin,
  output reg wave_output_pin_one,
  output reg wave_output_pin_two,
  output reg irq
);

  reg count_enable_bit;
  reg cascade_mode_bit;
  reg [3:0] count_clock_select_field;
  reg oscillator_divide_bit;
  reg wave_output_enable_one;
  reg wave_output_enable_two;
  reg [7:0] low_compare_reg;
  reg [7:0] high_compare_reg;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [31:0] next_prdata;
  reg next_pslverr;

  wire tick;
  wire [7:0] low_count_stage;
  wire [7:0] high_count_stage;
  wire low_match;
  wire high_match;
  wire low_at_max;
  wire full_match;
  wire count_step;
  wire low_zero;
  wire low_step;
  wire high_zero;
  wire high_step;
  wire low_stage_match_irq;
  wire high_stage_match_irq;
  wire setup;
  wire wr;
  wire [1:0] irq_set;
  wire [1:0] irq_clr;
  wire [1:0] next_irq_status;
  wire wr_stat;
  wire wr_outctl;
  wire irq_pending;
  localparam NIRQ = 2;

  // the decoder drives only the error answer; the write strobes compare paddr on their own
  function ctec_mapped;
    input [AW-1:0] a;
    begin
      if (a == `CTEC_OFF_MODE) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_CLKSEL) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_OUTCTL) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_CMP_LO) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_CMP_HI) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_COUNT) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_IRQ_STAT) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_IRQ_MASK) begin
        ctec_mapped = 1'b1;
      end else if (a == `CTEC_OFF_OSC) begin
        ctec_mapped = 1'b1;
      end else begin
        ctec_mapped = 1'b0;
      end
    end
  endfunction

  ctec_tick_gen u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .event_input_pin(event_input_pin),
    .count_clock_select_field(count_clock_select_field),
    .oscillator_divide_bit(oscillator_divide_bit),
    .tick(tick)
  );

  ctec_stage #(
    .WIDTH(8)
  ) u_low (
    .clk(clk),
    .rst_n(rst_n),
    .step(low_step),
    .zero(low_zero),
    .compare(low_compare_reg),
    .count(low_count_stage),
    .match(low_match),
    .at_max(low_at_max)
  );

  ctec_stage #(
    .WIDTH(8)
  ) u_high (
    .clk(clk),
    .rst_n(rst_n),
    .step(high_step),
    .zero(high_zero),
    .compare(high_compare_reg),
    .count(high_count_stage),
    .match(high_match),
    .at_max()
  );

  // counting path
  assign count_step = count_enable_bit & tick;
  assign full_match = low_match & high_match;
  // a match at the count clock clears instead of stepping, so compare N gives N+1 clocks
  assign low_zero = ~count_enable_bit | (count_step & (cascade_mode_bit ? full_match : low_match));
  assign low_step = count_step;
  // in single 8-bit use the high stage is held at zero
  assign high_zero = ~count_enable_bit | ~cascade_mode_bit | (count_step & full_match);
  assign high_step = count_step & cascade_mode_bit & low_at_max;
  assign low_stage_match_irq = count_step & low_match;
  assign high_stage_match_irq = count_step & cascade_mode_bit & full_match;

  // bus strobes
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready & ~pslverr;

  // write strobes shared by the status and output flip-flops
  assign wr_stat = wr & (paddr == `CTEC_OFF_IRQ_STAT);
  assign wr_outctl = wr & (paddr == `CTEC_OFF_OUTCTL);

  // interrupt status: a hardware set in the clear cycle survives
  assign irq_set = {high_stage_match_irq, low_stage_match_irq};
  assign irq_pending = |(next_irq_status & ~irq_mask);

  genvar gi;
  generate
    for (gi = 0; gi < NIRQ; gi = gi + 1) begin : g_irq_bit
      // a bit clears only where software writes a one
      assign irq_clr[gi] = wr_stat & pwdata[gi];
      assign next_irq_status[gi] = (irq_status[gi] & ~irq_clr[gi]) | irq_set[gi];
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 2'b00;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= irq_pending;
    end
  end

  // mode, clock select and oscillator setting
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_enable_bit <= 1'b0;
      cascade_mode_bit <= 1'b0;
      count_clock_select_field <= `CTEC_CLKSEL_RST;
      oscillator_divide_bit <= `CTEC_OSC_RST;
    end else if (wr) begin
      if (paddr == `CTEC_OFF_MODE) begin
        count_enable_bit <= pwdata[`CTEC_MODE_CE];
        cascade_mode_bit <= pwdata[`CTEC_MODE_CASC];
      end else if (paddr == `CTEC_OFF_CLKSEL) begin
        count_clock_select_field <= pwdata[3:0];
      end else if (paddr == `CTEC_OFF_OSC) begin
        oscillator_divide_bit <= pwdata[`CTEC_OSC_DIV];
      end
    end
  end

  // compares take effect at once; a value below the running count costs a wrap
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_compare_reg <= `CTEC_CMP_RST;
      high_compare_reg <= `CTEC_CMP_RST;
    end else if (wr) begin
      if (paddr == `CTEC_OFF_CMP_LO) begin
        low_compare_reg <= pwdata[7:0];
      end else if (paddr == `CTEC_OFF_CMP_HI) begin
        high_compare_reg <= pwdata[7:0];
      end
    end
  end

  // output enables and interrupt mask
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_output_enable_one <= 1'b0;
      wave_output_enable_two <= 1'b0;
      irq_mask <= `CTEC_MASK_RST;
    end else if (wr) begin
      if (paddr == `CTEC_OFF_OUTCTL) begin
        wave_output_enable_one <= pwdata[`CTEC_OUTC_OE1];
        wave_output_enable_two <= pwdata[`CTEC_OUTC_OE2];
      end else if (paddr == `CTEC_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // square-wave flip-flops; a level write wins over a toggle in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_output_pin_one <= 1'b0;
    end else if (wr_outctl && pwdata[`CTEC_OUTC_LVS1]) begin
      wave_output_pin_one <= 1'b1;
    end else if (wr_outctl && pwdata[`CTEC_OUTC_LVR1]) begin
      wave_output_pin_one <= 1'b0;
    end else if (low_stage_match_irq && wave_output_enable_one) begin
      wave_output_pin_one <= ~wave_output_pin_one;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_output_pin_two <= 1'b0;
    end else if (wr_outctl && pwdata[`CTEC_OUTC_OUTPUT_SET_LEVEL_TWO]) begin
      wave_output_pin_two <= 1'b1;
    end else if (wr_outctl && pwdata[`CTEC_OUTC_OUTPUT_RESET_LEVEL_TWO]) begin
      wave_output_pin_two <= 1'b0;
    end else if (high_stage_match_irq && wave_output_enable_two) begin
      wave_output_pin_two <= ~wave_output_pin_two;
    end
  end

  // read data is captured in the setup cycle, so both count bytes come from one edge
  always @* begin
    next_prdata = 32'h0000_0000;
    next_pslverr = ~ctec_mapped(paddr);
    if (paddr == `CTEC_OFF_MODE) begin
      next_prdata[`CTEC_MODE_CE] = count_enable_bit;
      next_prdata[`CTEC_MODE_CASC] = cascade_mode_bit;
    end else if (paddr == `CTEC_OFF_CLKSEL) begin
      next_prdata[3:0] = count_clock_select_field;
    end else if (paddr == `CTEC_OFF_OUTCTL) begin
      next_prdata[`CTEC_OUTC_OE1] = wave_output_enable_one;
      next_prdata[`CTEC_OUTC_OE2] = wave_output_enable_two;
    end else if (paddr == `CTEC_OFF_CMP_LO) begin
      next_prdata[7:0] = low_compare_reg;
    end else if (paddr == `CTEC_OFF_CMP_HI) begin
      next_prdata[7:0] = high_compare_reg;
    end else if (paddr == `CTEC_OFF_COUNT) begin
      next_prdata[15:0] = {high_count_stage, low_count_stage};
    end else if (paddr == `CTEC_OFF_IRQ_STAT) begin
      next_prdata[1:0] = irq_status;
    end else if (paddr == `CTEC_OFF_IRQ_MASK) begin
      next_prdata[1:0] = irq_mask;
    end else if (paddr == `CTEC_OFF_OSC) begin
      next_prdata[`CTEC_OSC_DIV] = oscillator_divide_bit;
    end
  end

  // every transfer takes exactly one access cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= next_pslverr;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // ctec_top

/* ctec_top_chk.sv */
`include "ctec_map.vh"
module ctec_top_chk #(
  parameter AW = 8
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire event_input_pin,
  input wire wave_output_pin_one,
  input wire wave_output_pin_two,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire oc_wr = pready && pwrite && paddr == `CTEC_OFF_OUTCTL;
  wire irq_wr = pready && pwrite && (paddr == `CTEC_OFF_IRQ_STAT || paddr == `CTEC_OFF_IRQ_MASK);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("ready without setup");
  chk_err_unmapped: assert property (pready && paddr > `CTEC_OFF_OSC |-> pslverr)
    else $error("no error on unmapped address");
  chk_rdata_unmapped: assert property (pready && !pwrite && paddr > `CTEC_OFF_OSC |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_err_mapped: assert property (pready && paddr <= `CTEC_OFF_OSC && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped address");
  chk_two_high: assert property (oc_wr && pwdata[`CTEC_OUTC_OUTPUT_SET_LEVEL_TWO] |=> wave_output_pin_two)
    else $error("output two not set");
  chk_two_low: assert property (oc_wr && pwdata[`CTEC_OUTC_OUTPUT_RESET_LEVEL_TWO] && !pwdata[`CTEC_OUTC_OUTPUT_SET_LEVEL_TWO] |=> !wave_output_pin_two)
    else $error("output two not reset");
  chk_one_high: assert property (oc_wr && pwdata[`CTEC_OUTC_LVS1] |=> wave_output_pin_one)
    else $error("output one not set");
  // a status clear drops irq at the write edge, a mask write one edge later
  chk_irq_fall: assert property ($fell(irq) |-> $past(irq_wr) || $past(irq_wr, 2))
    else $error("irq fell without status or mask write");
  chk_count_upper: assert property (pready && !pwrite && paddr == `CTEC_OFF_COUNT |-> prdata[31:16] == 16'h0000)
    else $error("count read upper half not zero");
endmodule // ctec_top_chk

bind ctec_top ctec_top_chk #(.AW(AW)) u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_input_pin(event_input_pin), .wave_output_pin_one(wave_output_pin_one),
  .wave_output_pin_two(wave_output_pin_two), .irq(irq));

/* ctec_top_tb.sv */
`include "ctec_map.vh"
module ctec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, err, p;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, ev, out1, out2, irq;
  int num_errors, n_checks, cyc, i, k, n;
  ctec_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_input_pin(ev),
    .wave_output_pin_one(out1), .wave_output_pin_two(out2), .irq(irq));
  ctec_ev_src EV (.clk(clk), .event_input_pin(ev));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task results;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      results();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check({31'h0, pready}, 32'h0000_0001);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask
  task waitc(input int c);
    repeat (c) @(posedge clk);
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    // direction, address and data wait for the first setup; a low psel gates them
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`CTEC_OFF_MODE, 32'h0000_0000);
    rdc(`CTEC_OFF_CLKSEL, 32'(`CTEC_CLKSEL_RST));
    rdc(`CTEC_OFF_OUTCTL, 32'h0000_0000);
    rdc(`CTEC_OFF_CMP_LO, 32'(`CTEC_CMP_RST));
    rdc(`CTEC_OFF_CMP_HI, 32'(`CTEC_CMP_RST));
    rdc(`CTEC_OFF_COUNT, 32'h0000_0000);
    rdc(`CTEC_OFF_IRQ_STAT, 32'h0000_0000);
    rdc(`CTEC_OFF_IRQ_MASK, 32'(`CTEC_MASK_RST));
    rdc(`CTEC_OFF_OSC, 32'(`CTEC_OSC_RST));
    wr(8'h24, 32'h0000_00FF);
    check({31'h0, err}, 32'h0000_0001);
    rdc(8'h24, 32'h0000_0000);
    for (i = 0; i < 16; i++) begin
      wr(`CTEC_OFF_CLKSEL, i);
      rdc(`CTEC_OFF_CLKSEL, i);
    end
    wr(`CTEC_OFF_OUTCTL, 32'h0000_00C0);
    waitc(1);
    check({out2, out1}, 2'b10);
    wr(`CTEC_OFF_OUTCTL, 32'h0000_0040);
    waitc(1);
    check({out2, out1}, 2'b00);
    wr(`CTEC_OFF_OUTCTL, 32'h0000_000C);
    waitc(1);
    check({out2, out1}, 2'b01);
    wr(`CTEC_OFF_OUTCTL, 32'h0000_0004);
    waitc(1);
    check({out2, out1}, 2'b00);
    // event counting in cascade, rising edge then falling edge
    wr(`CTEC_OFF_IRQ_MASK, 32'h0000_0000);
    wr(`CTEC_OFF_CMP_LO, 32'h0000_0002);
    wr(`CTEC_OFF_CMP_HI, 32'h0000_0000);
    wr(`CTEC_OFF_CLKSEL, 32'(`CTEC_SEL_EV_RISE));
    wr(`CTEC_OFF_MODE, 32'h0000_0005);
    EV.drive(1'b1);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0001);
    EV.drive(1'b0);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0001);
    EV.drive(1'b1);
    EV.drive(1'b0);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0002);
    EV.drive(1'b1);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0000);
    rdc(`CTEC_OFF_IRQ_STAT, 32'h0000_0003);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`CTEC_OFF_IRQ_STAT, 32'h0000_0003);
    waitc(2);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`CTEC_OFF_CLKSEL, 32'(`CTEC_SEL_EV_FALL));
    EV.drive(1'b0);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0001);
    wr(`CTEC_OFF_MODE, 32'h0000_0004);
    wr(`CTEC_OFF_CMP_LO, 32'h0000_0000);
    wr(`CTEC_OFF_IRQ_STAT, 32'h0000_0003);
    wr(`CTEC_OFF_MODE, 32'h0000_0005);
    EV.drive(1'b1);
    EV.drive(1'b0);
    rdc(`CTEC_OFF_IRQ_STAT, 32'h0000_0003);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0000);
    // 16-bit interval timer, compare 0x0105 on the fastest internal clock
    wr(`CTEC_OFF_MODE, 32'h0000_0004);
    wr(`CTEC_OFF_IRQ_MASK, 32'h0000_0001);
    wr(`CTEC_OFF_CMP_HI, 32'h0000_0001);
    wr(`CTEC_OFF_CMP_LO, 32'h0000_0005);
    wr(`CTEC_OFF_OUTCTL, 32'h0000_0011);
    wr(`CTEC_OFF_CLKSEL, 32'h0000_0006);
    wr(`CTEC_OFF_OSC, 32'h0000_0001);
    wr(`CTEC_OFF_IRQ_STAT, 32'h0000_0003);
    wr(`CTEC_OFF_MODE, 32'h0000_0005);
    for (k = 0; k < 3000 && irq !== 1'b1; k++) waitc(1);
    check({out2, out1}, 2'b10);
    rdc(`CTEC_OFF_IRQ_STAT, 32'h0000_0003);
    for (i = 1; i >= 0; i--) begin
      wr(`CTEC_OFF_OSC, i);
      p = out2;
      for (k = 0; k < 3000 && out2 === p; k++) waitc(1);
      p = out2;
      n = 0;
      while (out2 === p && n < 3000) begin
        waitc(1);
        n++;
      end
      check(n, 524 << (1 - i));
    end
    wr(`CTEC_OFF_MODE, 32'h0000_0004);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0000);
    wr(`CTEC_OFF_IRQ_MASK, 32'h0000_0003);
    waitc(2);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`CTEC_OFF_IRQ_MASK, 32'h0000_0001);
    waitc(2);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`CTEC_OFF_IRQ_STAT, 32'h0000_0003);
    waitc(2);
    check({31'h0, irq}, 32'h0000_0000);
    waitc(50);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0000);
    // 8-bit mode: compare lowered below the running count waits for the wrap
    wr(`CTEC_OFF_OSC, 32'h0000_0001);
    wr(`CTEC_OFF_CMP_LO, 32'h0000_0040);
    wr(`CTEC_OFF_MODE, 32'h0000_0001);
    waitc(96);
    wr(`CTEC_OFF_CMP_LO, 32'h0000_0010);
    waitc(300);
    rdc(`CTEC_OFF_IRQ_STAT, 32'h0000_0000);
    waitc(300);
    rdc(`CTEC_OFF_IRQ_STAT, 32'h0000_0001);
    // reset in mid-run: outputs drop and registers return to their reset values
    rst_n <= 1'b0;
    waitc(2);
    check({out2, out1, irq}, 3'b000);
    rst_n <= 1'b1;
    rdc(`CTEC_OFF_MODE, 32'h0000_0000);
    rdc(`CTEC_OFF_IRQ_MASK, 32'(`CTEC_MASK_RST));
    rdc(`CTEC_OFF_IRQ_STAT, 32'h0000_0000);
    rdc(`CTEC_OFF_COUNT, 32'h0000_0000);
    results();
  end
endmodule // ctec_top_tb
